// ==== core/rtsr_pkg.sv ====
// constants and types shared by the terminal soft reset and self-test block
package rtsr_pkg;
	localparam int ADDR_W = 13;
	localparam int DATA_W = 16;
	localparam logic [12:0] OFF_MC1 = 13'h0000;
	localparam logic [12:0] OFF_MSR = 13'h0001;
	localparam logic [12:0] OFF_HWP = 13'h0006;
	localparam logic [12:0] OFF_RTP = 13'h0009;
	localparam logic [12:0] OFF_TFAIL = 13'h0024;
	localparam logic [12:0] OFF_STC = 13'h0028;
	localparam logic [12:0] OFF_MC2 = 13'h004E;
	localparam logic [12:0] OFF_TCK = 13'h01C0;
	localparam logic [12:0] OFF_ILL = 13'h0200;
	localparam logic [12:0] OFF_DSC = 13'h0400;
	localparam logic [12:0] RAM_CLR_LO = 13'h0052;
	localparam logic [12:0] RAM_TOP = 13'h1FFF;
	localparam int SR_REG_N = 10;
	localparam int ILL_N = 256;
	localparam int DSC_N = 512;
	localparam int SR_COUNT = SR_REG_N + ILL_N + DSC_N;
	localparam logic [9:0] SR_LAST = 10'(SR_COUNT - 1);
	localparam int B_RUN = 4;
	localparam int B_ENA = 6;
	localparam int B_SRST = 10;
	localparam int B_BUSY = 7;
	localparam int B_RIF = 13;
	localparam logic [15:0] HWP_SR_CLR = 16'h000C;
	localparam logic [15:0] RTP_SR_CLR = 16'h01F8;
	localparam int B_GO = 10;
	localparam int B_FORCE = 14;
	localparam int B_PASS = 8;
	localparam int B_FAIL = 9;
	localparam logic [15:0] STC_RO_MASK = 16'h0703;
	localparam logic [2:0] SEL_PAT = 3'h1;
	localparam logic [2:0] SEL_WZ = 3'h2;
	localparam logic [2:0] SEL_VZ = 3'h3;
	localparam logic [2:0] SEL_WO = 3'h4;
	localparam logic [2:0] SEL_VO = 3'h5;
	localparam logic [2:0] SEL_ID = 3'h6;
	localparam logic [15:0] UNL_MASK = 16'hF03F;
	localparam logic [15:0] UNL1_VAL = 16'hA03A;
	localparam logic [15:0] UNL2_VAL = 16'h5005;
	localparam int CLK_NS = 10;
	localparam int STRAP_NS = 200;
	localparam int STRAP_CYC = (STRAP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [4:0] STRAP_LAST = 5'(STRAP_CYC - 1);
	localparam int P_BUSY = 2;
	localparam int P_SKIP = 1;
	localparam int P_TEST = 0;
	typedef enum logic [3:0] {S_STRAP, S_WR, S_RD, S_CK, S_NEXT, S_IDLE, S_FAILED, S_SR_ZERO,
		S_SR_EE, S_SR_WR, S_SR_RD, S_SR_CK, S_SR_SUM, S_SR_CFG} rtsr_state_t;
	typedef enum logic [1:0] {PK_ZERO, PK_ONES, PK_ADDR} rtsr_pat_t;
	typedef enum logic {J_PWR, J_BIST} rtsr_job_t;
	function automatic logic [12:0] rtsr_sr_addr(input logic [9:0] idx);
		logic [12:0] a;
		a = 13'h0000;
		if (idx >= 10'(SR_REG_N + ILL_N)) a = OFF_DSC + 13'(idx - 10'(SR_REG_N + ILL_N));
		else if (idx >= 10'(SR_REG_N)) a = OFF_ILL + 13'(idx - 10'(SR_REG_N));
		else begin
			case (idx[3:0])
			4'h0: a = 13'h000F;
			4'h1: a = 13'h0012;
			4'h2: a = 13'h0013;
			4'h3: a = 13'h0016;
			4'h4: a = 13'h0017;
			4'h5: a = 13'h0019;
			4'h6: a = 13'h001C;
			4'h7: a = 13'h001D;
			4'h8: a = 13'h001F;
			default: a = 13'h004A;
			endcase
		end
		return a;
	endfunction : rtsr_sr_addr
	function automatic logic [12:0] rtsr_zero_addr(input logic [1:0] i);
		logic [12:0] a;
		case (i)
		2'h0: a = 13'h0018;
		2'h1: a = 13'h001A;
		2'h2: a = 13'h001E;
		default: a = 13'h0049;
		endcase
		return a;
	endfunction : rtsr_zero_addr
endpackage : rtsr_pkg

// ==== core/rtsr_ram.sv ====
// single-port word memory with registered read data
`timescale 1ns/1ps
module rtsr_ram #(
	parameter int AW = 13,
	parameter int DW = 16
) (
	// clock
	input wire logic clk,
	// access
	input wire logic we,
	input wire logic [AW-1:0] addr,
	input wire logic [DW-1:0] wdata,
	output logic [DW-1:0] rdata_q
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// no reset on the array: contents are defined only by host writes, the tests, soft reset zeroing and reloads
	always_ff @(posedge clk) begin
		if (we) begin
			mem[addr] <= wdata;
		end
		rdata_q <= mem[addr];
	end
endmodule : rtsr_ram

// ==== core/rtsr_top.sv ====
// soft reset sequencer, busy-only mode and RAM self-test for the terminal
`timescale 1ns/1ps
module rtsr_top (
	// clock and master reset
	input wire logic CLK,
	input wire logic ARST_N,
	// host register port
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [rtsr_pkg::ADDR_W-1:0] REG_ADDR,
	input wire logic [rtsr_pkg::DATA_W-1:0] REG_WDATA,
	output logic [rtsr_pkg::DATA_W-1:0] REG_RDATA,
	// mode pins
	input wire logic BUSY_ONLY_MODE_PIN,
	input wire logic SKIP_POWER_UP_RAM_TEST,
	input wire logic TEST_PIN,
	// pending events from the protocol engine
	input wire logic [rtsr_pkg::DATA_W-1:0] HW_EVENT,
	input wire logic [rtsr_pkg::DATA_W-1:0] RT_EVENT,
	// eeprom image reader
	output logic EE_REQ,
	output logic [rtsr_pkg::ADDR_W-1:0] EE_WORD_ADDR,
	input wire logic EE_ACK,
	input wire logic [rtsr_pkg::DATA_W-1:0] EE_DATA,
	// eeprom image copy
	input wire logic [rtsr_pkg::DATA_W-1:0] UNLOCK_WORD1,
	input wire logic [rtsr_pkg::DATA_W-1:0] UNLOCK_WORD2,
	output logic [rtsr_pkg::DATA_W-1:0] IMAGE_CFG_WORD,
	// status
	output logic READY,
	output logic BUSY_ONLY,
	output logic TERMINAL_RUN,
	output logic [5:0] LOOPBACK_CTRL
);
	import rtsr_pkg::*;

	rtsr_state_t state_q;
	rtsr_pat_t pat_q;
	rtsr_job_t job_q;
	logic [4:0] cnt_q;
	logic [12:0] addr_q, end_q, ee_addr_q, tfail_q;
	logic down_q, err_q;
	logic [1:0] ph_q;
	logic [2:0] sel_q;
	logic [9:0] idx_q;
	logic [15:0] sum_q, ee_q;
	logic [2:0] pins_s1_q, pins_s2_q;
	logic [15:0] cfg1_q, hwp_q, rtp_q, stc_q, rreg_q, image_q;
	logic rif_q, ckf_q, busy_q, rsel_q;
	logic ram_we;
	logic [12:0] ram_addr;
	logic [15:0] ram_wdata, ram_rdata, exp_val;
	logic test_s, sr_go, sr_start, sr_mis, sr_ckf, sr_auto, bist_go, more_inc, bist_done;
	logic ck_mis, idle, stc_wr, unlock_ok;

	function automatic logic [15:0] pat_val(input rtsr_pat_t p, input logic [12:0] a);
		logic [15:0] v;
		case (p)
		PK_ZERO: v = 16'h0000;
		PK_ONES: v = 16'hFFFF;
		default: v = {3'h0, a};
		endcase
		return v;
	endfunction : pat_val

	// pins cross from outside; only the second stage is used
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			pins_s1_q <= 3'h0;
			pins_s2_q <= 3'h0;
		end else begin
			pins_s1_q <= {BUSY_ONLY_MODE_PIN, SKIP_POWER_UP_RAM_TEST, TEST_PIN};
			pins_s2_q <= pins_s1_q;
		end
	end

	assign test_s = pins_s2_q[P_TEST];
	assign idle = (state_q == S_IDLE);
	assign sr_go = REG_WR && REG_ADDR == OFF_MSR && REG_WDATA[B_SRST];
	assign sr_start = idle && sr_go;
	assign stc_wr = REG_WR && REG_ADDR == OFF_STC && test_s;
	assign bist_go = idle && stc_wr && REG_WDATA[B_GO] && REG_WDATA[13:11] != 3'h0
		&& REG_WDATA[13:11] != 3'h7;
	assign exp_val = pat_val(pat_q, addr_q);
	assign ck_mis = (state_q == S_CK) && (ram_rdata != exp_val);
	assign sr_mis = (state_q == S_SR_CK) && (ram_rdata != ee_q);
	assign sr_ckf = (state_q == S_SR_SUM) && EE_ACK && (16'(sum_q + EE_DATA) != 16'h0000);
	assign sr_auto = (state_q == S_SR_CFG) && EE_ACK && EE_DATA[B_RUN] && EE_DATA[B_ENA]
		&& !rif_q && !ckf_q;
	assign more_inc = (ph_q == 2'h0) && (job_q == J_PWR || sel_q == SEL_ID || sel_q == SEL_PAT);
	assign bist_done = (state_q == S_NEXT) && (job_q == J_BIST) && !more_inc;

	// sequencer: strap wait, memory sweeps and the soft reset walk
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_q <= S_STRAP;
			cnt_q <= 5'h00;
			addr_q <= 13'h0000;
			end_q <= 13'h0000;
			down_q <= 1'b0;
			pat_q <= PK_ADDR;
			job_q <= J_PWR;
			ph_q <= 2'h0;
			err_q <= 1'b0;
			sel_q <= 3'h0;
			idx_q <= 10'h000;
			sum_q <= 16'h0000;
			ee_q <= 16'h0000;
			ee_addr_q <= 13'h0000;
		end else begin
			case (state_q)
			S_STRAP: begin
				cnt_q <= cnt_q + 5'h01;
				if (cnt_q == STRAP_LAST) begin
					if (pins_s2_q[P_SKIP]) begin
						state_q <= S_IDLE;
					end else begin
						addr_q <= 13'h0000;
						end_q <= RAM_TOP;
						down_q <= 1'b0;
						pat_q <= PK_ADDR;
						job_q <= J_PWR;
						ph_q <= 2'h0;
						err_q <= 1'b0;
						state_q <= S_WR;
					end
				end
			end
			S_WR: begin
				if (addr_q == end_q) begin
					state_q <= S_NEXT;
				end else begin
					addr_q <= down_q ? addr_q - 13'h0001 : addr_q + 13'h0001;
				end
			end
			S_RD: begin
				state_q <= S_CK;
			end
			S_CK: begin
				if (ck_mis) begin
					err_q <= 1'b1;
				end
				if (addr_q == end_q) begin
					state_q <= S_NEXT;
				end else begin
					addr_q <= down_q ? addr_q - 13'h0001 : addr_q + 13'h0001;
					state_q <= S_RD;
				end
			end
			S_NEXT: begin
				if (more_inc) begin
					addr_q <= RAM_TOP;
					end_q <= 13'h0000;
					down_q <= 1'b1;
					ph_q <= 2'h1;
					state_q <= S_RD;
				end else if (job_q == J_PWR && ph_q == 2'h1) begin
					if (err_q) begin
						state_q <= S_FAILED;
					end else begin
						addr_q <= RAM_CLR_LO;
						end_q <= RAM_TOP;
						down_q <= 1'b0;
						pat_q <= PK_ZERO;
						ph_q <= 2'h2;
						state_q <= S_WR;
					end
				end else begin
					state_q <= S_IDLE;
				end
			end
			S_IDLE: begin
				if (sr_start) begin
					idx_q <= 10'h000;
					sum_q <= 16'h0000;
					state_q <= S_SR_ZERO;
				end else if (bist_go) begin
					sel_q <= REG_WDATA[13:11];
					err_q <= REG_WDATA[B_FORCE];
					job_q <= J_BIST;
					ph_q <= 2'h0;
					addr_q <= 13'h0000;
					end_q <= RAM_TOP;
					down_q <= 1'b0;
					if (REG_WDATA[13:11] == SEL_WZ || REG_WDATA[13:11] == SEL_VZ) begin
						pat_q <= PK_ZERO;
					end else if (REG_WDATA[13:11] == SEL_WO || REG_WDATA[13:11] == SEL_VO) begin
						pat_q <= PK_ONES;
					end else begin
						pat_q <= PK_ADDR;
					end
					if (REG_WDATA[13:11] == SEL_VZ || REG_WDATA[13:11] == SEL_VO) begin
						state_q <= S_RD;
					end else begin
						state_q <= S_WR;
					end
				end
			end
			S_SR_ZERO: begin
				idx_q <= idx_q + 10'h001;
				if (idx_q[1:0] == 2'h3) begin
					idx_q <= 10'h000;
					ee_addr_q <= rtsr_sr_addr(10'h000);
					state_q <= S_SR_EE;
				end
			end
			S_SR_EE: begin
				if (EE_ACK) begin
					ee_q <= EE_DATA;
					sum_q <= 16'(sum_q + EE_DATA);
					state_q <= S_SR_WR;
				end
			end
			S_SR_WR: begin
				state_q <= S_SR_RD;
			end
			S_SR_RD: begin
				state_q <= S_SR_CK;
			end
			S_SR_CK: begin
				if (idx_q == SR_LAST) begin
					ee_addr_q <= OFF_TCK;
					state_q <= S_SR_SUM;
				end else begin
					idx_q <= idx_q + 10'h001;
					ee_addr_q <= rtsr_sr_addr(idx_q + 10'h001);
					state_q <= S_SR_EE;
				end
			end
			S_SR_SUM: begin
				if (EE_ACK) begin
					ee_addr_q <= OFF_MC1;
					state_q <= S_SR_CFG;
				end
			end
			S_SR_CFG: begin
				if (EE_ACK) begin
					state_q <= S_IDLE;
				end
			end
			default: begin
				state_q <= S_FAILED;
			end
			endcase
		end
	end

	// memory port: the sequencer owns it except when idle
	always_comb begin
		ram_we = 1'b0;
		ram_addr = REG_ADDR;
		ram_wdata = REG_WDATA;
		case (state_q)
		S_WR: begin
			ram_we = 1'b1;
			ram_addr = addr_q;
			ram_wdata = exp_val;
		end
		S_RD: ram_addr = addr_q;
		S_SR_ZERO: begin
			ram_we = 1'b1;
			ram_addr = rtsr_zero_addr(idx_q[1:0]);
			ram_wdata = 16'h0000;
		end
		S_SR_WR: begin
			ram_we = 1'b1;
			ram_addr = rtsr_sr_addr(idx_q);
			ram_wdata = ee_q;
		end
		S_SR_RD: ram_addr = rtsr_sr_addr(idx_q);
		S_IDLE: ram_we = REG_WR && REG_ADDR != OFF_MC1 && REG_ADDR != OFF_MSR
			&& REG_ADDR != OFF_HWP && REG_ADDR != OFF_RTP && REG_ADDR != OFF_TFAIL
			&& REG_ADDR != OFF_STC && REG_ADDR != OFF_MC2;
		default: ram_we = 1'b0;
		endcase
	end

	rtsr_ram #(
		.AW(ADDR_W),
		.DW(DATA_W)
	) u_ram (
		.clk(CLK),
		.we(ram_we),
		.addr(ram_addr),
		.wdata(ram_wdata),
		.rdata_q(ram_rdata)
	);

	// configuration register 1: run bit
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cfg1_q <= 16'h0000;
		end else begin
			if (REG_WR && REG_ADDR == OFF_MC1) begin
				cfg1_q <= REG_WDATA;
			end
			if (sr_start) begin
				cfg1_q[B_RUN] <= 1'b0;
			end
			if (sr_auto) begin
				cfg1_q[B_RUN] <= 1'b1;
				cfg1_q[B_ENA] <= 1'b1;
			end
		end
	end

	// error flags: set wins over a host write-one clear
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rif_q <= 1'b0;
			ckf_q <= 1'b0;
			tfail_q <= 13'h0000;
		end else begin
			if (sr_start) begin
				rif_q <= 1'b0;
				ckf_q <= 1'b0;
			end else begin
				rif_q <= sr_mis | (rif_q & ~(REG_WR && REG_ADDR == OFF_MSR && REG_WDATA[0]));
				ckf_q <= sr_ckf | (ckf_q & ~(REG_WR && REG_ADDR == OFF_MSR && REG_WDATA[1]));
			end
			if (sr_mis && !rif_q) begin
				tfail_q <= rtsr_sr_addr(idx_q);
			end else if (ck_mis && !err_q) begin
				tfail_q <= addr_q;
			end
		end
	end

	// pending registers; engine events are muted in busy-only mode, the soft reset mismatch bit 13 is not
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			hwp_q <= 16'h0000;
			rtp_q <= 16'h0000;
		end else begin
			hwp_q <= (hwp_q & ~((REG_WR && REG_ADDR == OFF_HWP) ? REG_WDATA : 16'h0000)
				& ~(sr_start ? HWP_SR_CLR : 16'h0000))
				| (busy_q ? 16'h0000 : HW_EVENT) | (sr_mis ? 16'h2000 : 16'h0000);
			rtp_q <= (rtp_q & ~((REG_WR && REG_ADDR == OFF_RTP) ? REG_WDATA : 16'h0000)
				& ~(sr_start ? RTP_SR_CLR : 16'h0000))
				| (busy_q ? 16'h0000 : RT_EVENT);
		end
	end

	// busy-only mode latched once after reset release
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			busy_q <= 1'b0;
		end else begin
			if (state_q == S_STRAP && cnt_q == STRAP_LAST) begin
				busy_q <= pins_s2_q[P_BUSY];
			end else if ((REG_WR && REG_ADDR == OFF_MC2 && REG_WDATA[B_BUSY])
				|| (cfg1_q[B_RUN] && cfg1_q[B_ENA])) begin
				busy_q <= 1'b0;
			end
		end
	end

	// self-test control; go bit is not stored, it reads back while a test runs
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			stc_q <= 16'h0000;
		end else begin
			if (stc_wr) begin
				stc_q <= (REG_WDATA & ~STC_RO_MASK) | (stc_q & STC_RO_MASK & 16'h0300);
			end
			if (bist_go) begin
				stc_q[B_PASS] <= 1'b0;
				stc_q[B_FAIL] <= 1'b0;
			end else if (bist_done) begin
				stc_q[B_PASS] <= !err_q;
				stc_q[B_FAIL] <= err_q;
			end
		end
	end

	// register reads; memory data follows one cycle after the strobe
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rreg_q <= 16'h0000;
			rsel_q <= 1'b0;
		end else begin
			rsel_q <= 1'b0;
			if (REG_RD) begin
				if (REG_ADDR == OFF_MC1) begin
					rreg_q <= cfg1_q;
				end else if (REG_ADDR == OFF_MSR) begin
					rreg_q <= {5'h00, state_q >= S_SR_ZERO, 8'h00, ckf_q, rif_q};
				end else if (REG_ADDR == OFF_HWP) begin
					rreg_q <= hwp_q;
				end else if (REG_ADDR == OFF_RTP) begin
					rreg_q <= rtp_q;
				end else if (REG_ADDR == OFF_TFAIL) begin
					rreg_q <= {3'h0, tfail_q};
				end else if (REG_ADDR == OFF_STC) begin
					rreg_q <= test_s ? (stc_q | {5'h00, job_q == J_BIST && !idle, 10'h000})
						: 16'h0000;
				end else if (REG_ADDR == OFF_MC2) begin
					rreg_q <= {8'h00, busy_q, 7'h00};
				end else begin
					rreg_q <= 16'h0000;
					rsel_q <= idle;
				end
			end
		end
	end

	// image word for the copy logic: run survives only with both unlock words
	assign unlock_ok = ((UNLOCK_WORD1 & UNL_MASK) == UNL1_VAL)
		&& ((UNLOCK_WORD2 & UNL_MASK) == UNL2_VAL);
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			image_q <= 16'h0000;
		end else begin
			image_q <= {cfg1_q[15:5], cfg1_q[B_RUN] & unlock_ok, cfg1_q[3:0]};
		end
	end

	assign REG_RDATA = rsel_q ? ram_rdata : rreg_q;
	assign EE_REQ = (state_q == S_SR_EE) || (state_q == S_SR_SUM) || (state_q == S_SR_CFG);
	assign EE_WORD_ADDR = ee_addr_q;
	assign IMAGE_CFG_WORD = image_q;
	assign READY = idle;
	assign BUSY_ONLY = busy_q;
	assign TERMINAL_RUN = cfg1_q[B_RUN];
	assign LOOPBACK_CTRL = test_s ? stc_q[7:2] : 6'h00;

	a_sr_start_seq: assert property (@(posedge CLK) disable iff (!ARST_N)
		sr_start |=> state_q == S_SR_ZERO ##4 state_q == S_SR_EE)
		else $error("soft reset did not start its sequence");
	a_sr_run_clear: assert property (@(posedge CLK) disable iff (!ARST_N)
		sr_start |=> !cfg1_q[B_RUN] && ((rtp_q & RTP_SR_CLR)
		== (RTP_SR_CLR & ($past(busy_q) ? 16'h0000 : $past(RT_EVENT)))))
		else $error("soft reset left run or pending bits");
	a_sr_zero_wr: assert property (@(posedge CLK) disable iff (!ARST_N)
		state_q == S_SR_ZERO |-> ram_we && ram_wdata == 16'h0000)
		else $error("soft reset zeroing write missing");
	a_ready_low: assert property (@(posedge CLK) disable iff (!ARST_N)
		sr_start |=> !READY [*5])
		else $error("ready high during soft reset");
	a_busy_read: assert property (@(posedge CLK) disable iff (!ARST_N)
		REG_RD && REG_ADDR == OFF_MC2 |=> REG_RDATA[B_BUSY] == $past(busy_q))
		else $error("busy-only status bit wrong");
	a_busy_exit: assert property (@(posedge CLK) disable iff (!ARST_N)
		cfg1_q[B_RUN] && cfg1_q[B_ENA] |=> !busy_q)
		else $error("busy-only mode did not end");
	a_stc_ro_bits: assert property (@(posedge CLK) disable iff (!ARST_N)
		stc_wr && !bist_done |=> stc_q[1:0] == 2'h0
		&& stc_q[9:8] == ($past(bist_go) ? 2'h0 : $past(stc_q[9:8])))
		else $error("read-only self-test bits changed by write");
	a_stc_gate: assert property (@(posedge CLK) disable iff (!ARST_N)
		REG_WR && REG_ADDR == OFF_STC && !test_s |=> $stable(stc_q[15:10]))
		else $error("self-test register written while test pin low");
	a_strap_time: assert property (@(posedge CLK) disable iff (!ARST_N)
		state_q == S_STRAP && cnt_q == STRAP_LAST |=> busy_q == $past(pins_s2_q[P_BUSY]))
		else $error("busy-only strap not sampled");
endmodule : rtsr_top

// ==== tb/rtsr_ee_model.sv ====
// image eeprom model answering the word reader of the soft reset sequencer
`timescale 1ns/1ps
module rtsr_ee_model (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// word reader
	input wire logic ee_req,
	input wire logic [12:0] ee_word_addr,
	output logic ee_ack,
	output logic [15:0] ee_data,
	// behaviour
	input wire logic slow,
	input wire logic bad_sum
);
	logic [15:0] sum;
	logic [2:0] cnt;
	logic [12:0] regs [10] = '{13'h000F, 13'h0012, 13'h0013, 13'h0016, 13'h0017,
		13'h0019, 13'h001C, 13'h001D, 13'h001F, 13'h004A};
	// config image carries run and enable, as a copy with good unlock words leaves it
	function automatic logic [15:0] word(input logic [12:0] a);
		return (a == 13'h0000) ? 16'h0050 : 16'h3C00 ^ {3'h0, a};
	endfunction : word
	// checksum word cancels the tally of every reloaded location
	initial begin
		sum = 16'h0000;
		foreach (regs[i]) sum += word(regs[i]);
		for (int a = 'h200; a < 'h300; a++) sum += word(13'(a));
		for (int a = 'h400; a < 'h600; a++) sum += word(13'(a));
	end
	// released data line toggles so a stale sample never looks right
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ee_ack <= 1'b0;
			ee_data <= 16'h0000;
			cnt <= 3'h0;
		end else if (ee_ack) begin
			ee_ack <= 1'b0;
			ee_data <= ~ee_data;
		end else if (ee_req && cnt >= (slow ? 3'h4 : 3'h0)) begin
			ee_ack <= 1'b1;
			ee_data <= (ee_word_addr == 13'h01C0) ? 16'h0000 - sum + {15'h0, bad_sum}
				: word(ee_word_addr);
			cnt <= 3'h0;
		end else begin
			ee_data <= ~ee_data;
			if (ee_req) cnt <= cnt + 3'h1;
		end
	end
endmodule : rtsr_ee_model

// ==== tb/testbench.sv ====
// register level tests of soft reset, busy-only mode and ram self-test
`timescale 1ns/1ps
module testbench;
	import rtsr_pkg::*;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [12:0] reg_addr = 13'h0000;
	logic [15:0] reg_wdata = 16'h0000;
	logic [15:0] reg_rdata;
	logic busy_pin = 1'b0;
	logic skip = 1'b1;
	logic test_pin = 1'b0;
	logic [15:0] hw_ev = 16'h0000;
	logic [15:0] rt_ev = 16'h0000;
	logic slow = 1'b0;
	logic bad_sum = 1'b0;
	logic [15:0] unl1 = 16'hA5FA;
	logic [15:0] unl2 = 16'h5AC5;
	logic ee_req, ee_ack, ready, busy, run;
	logic [12:0] ee_addr;
	logic [15:0] ee_data, img;
	logic [5:0] loop;
	int mismatches = 0;
	int total_checks = 0;
	always #5 clk = ~clk;
	rtsr_top uut (.CLK(clk), .ARST_N(arst_n), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
		.BUSY_ONLY_MODE_PIN(busy_pin), .SKIP_POWER_UP_RAM_TEST(skip), .TEST_PIN(test_pin),
		.HW_EVENT(hw_ev), .RT_EVENT(rt_ev), .EE_REQ(ee_req), .EE_WORD_ADDR(ee_addr),
		.EE_ACK(ee_ack), .EE_DATA(ee_data), .UNLOCK_WORD1(unl1), .UNLOCK_WORD2(unl2),
		.IMAGE_CFG_WORD(img), .READY(ready), .BUSY_ONLY(busy), .TERMINAL_RUN(run),
		.LOOPBACK_CTRL(loop));
	rtsr_ee_model ee (.clk(clk), .arst_n(arst_n), .ee_req(ee_req), .ee_word_addr(ee_addr),
		.ee_ack(ee_ack), .ee_data(ee_data), .slow(slow), .bad_sum(bad_sum));
	task automatic stop_test;
		if (mismatches == 0 && total_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : stop_test
	task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [12:0] a, input logic [15:0] d);
		@(posedge clk);
		#1 reg_wr = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask : wr
	// read data is only good in the cycle right after the strobe
	task automatic rdc(input string name, input logic [12:0] a, input logic [15:0] m,
		input logic [15:0] exp);
		@(posedge clk);
		#1 reg_rd = 1'b1;
		reg_addr = a;
		@(posedge clk);
		#1 reg_rd = 1'b0;
		chk(name, reg_rdata & m, exp);
	endtask : rdc
	task automatic wait_ready(input int lim);
		int n;
		n = 0;
		while (ready !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1 n++;
		end
		chk("ready", 16'(ready), 16'h0001);
	endtask : wait_ready
	// one spare edge first, so a start that lands late is not missed
	task automatic run_op(input logic [12:0] a, input logic [15:0] d);
		wr(a, d);
		@(posedge clk);
		#1 wait_ready(20000);
	endtask : run_op
	task automatic rst(input logic s, input logic b);
		arst_n = 1'b0;
		skip = s;
		busy_pin = b;
		repeat (12) @(posedge clk);
		#1 chk("ready", 16'(ready), 16'h0000);
		arst_n = 1'b1;
	endtask : rst
	initial begin
		#1050000;
		mismatches++;
		stop_test();
	end
	initial begin
		rst(1'b1, 1'b1);
		wait_ready(30);
		chk("busy_only", 16'(busy), 16'h0001);
		rdc("mc2", OFF_MC2, 16'h0080, 16'h0080);
		wr(OFF_MC2, 16'h0080);
		rdc("mc2", OFF_MC2, 16'h0080, 16'h0000);
		chk("busy_only", 16'(busy), 16'h0000);
		wr(13'h0018, 16'h1234);
		wr(13'h0049, 16'h4321);
		wr(OFF_MC1, 16'h0010);
		@(posedge clk);
		#1 hw_ev = HWP_SR_CLR;
		rt_ev = RTP_SR_CLR;
		@(posedge clk);
		#1 hw_ev = 16'h0000;
		rt_ev = 16'h0000;
		rdc("hw_pend", OFF_HWP, HWP_SR_CLR, HWP_SR_CLR);
		wr(OFF_MSR, 16'h0400);
		@(posedge clk);
		#1 chk("ready", 16'(ready), 16'h0000);
		chk("run", 16'(run), 16'h0000);
		rdc("msr_busy", OFF_MSR, 16'h0400, 16'h0400);
		wait_ready(20000);
		chk("run", 16'(run), 16'h0001);
		rdc("hw_pend", OFF_HWP, HWP_SR_CLR, 16'h0000);
		rdc("rt_pend", OFF_RTP, RTP_SR_CLR, 16'h0000);
		rdc("op_status", 13'h0018, 16'hFFFF, 16'h0000);
		rdc("time_tag", 13'h0049, 16'hFFFF, 16'h0000);
		rdc("illegal_tab", 13'h0200, 16'hFFFF, 16'h3E00);
		rdc("desc_tab", 13'h05FF, 16'hFFFF, 16'h39FF);
		rdc("tag_util", 13'h004A, 16'hFFFF, 16'h3C4A);
		rdc("msr_err", OFF_MSR, 16'h0003, 16'h0000);
		slow = 1'b1;
		bad_sum = 1'b1;
		run_op(OFF_MSR, 16'h0400);
		rdc("msr_err", OFF_MSR, 16'h0003, 16'h0002);
		chk("run", 16'(run), 16'h0000);
		wr(OFF_MC1, 16'h0050);
		repeat (2) @(posedge clk);
		#1 chk("run", 16'(run), 16'h0001);
		chk("image_cfg", img, 16'h0050);
		unl2 = 16'h5AC6;
		repeat (2) @(posedge clk);
		#1 chk("image_cfg", img, 16'h0040);
		wr(OFF_STC, 16'h00FC);
		rdc("self_test", OFF_STC, 16'hFFFF, 16'h0000);
		test_pin = 1'b1;
		wr(13'h0100, 16'hBEEF);
		wr(OFF_STC, 16'h14FC);
		@(posedge clk);
		#1 chk("ready", 16'(ready), 16'h0000);
		wait_ready(20000);
		rdc("self_test", OFF_STC, 16'hFFFF, 16'h11FC);
		chk("loopback", 16'(loop), 16'h003F);
		rdc("ram", 13'h0100, 16'hFFFF, 16'h0000);
		wr(13'h0123, 16'h0001);
		run_op(OFF_STC, 16'h1C00);
		rdc("self_test", OFF_STC, 16'hFFFF, 16'h1A00);
		rdc("fail_addr", OFF_TFAIL, 16'hFFFF, 16'h0123);
		run_op(OFF_STC, 16'h2C03);
		rdc("self_test", OFF_STC, 16'hFFFF, 16'h2A00);
		run_op(OFF_STC, 16'h2400);
		rdc("self_test", OFF_STC, 16'hFFFF, 16'h2100);
		rdc("ram", 13'h0100, 16'hFFFF, 16'hFFFF);
		wr(OFF_STC, 16'h0400);
		@(posedge clk);
		#1 chk("ready", 16'(ready), 16'h0001);
		rdc("self_test", OFF_STC, 16'h0400, 16'h0000);
		test_pin = 1'b0;
		repeat (3) @(posedge clk);
		#1 chk("loopback", 16'(loop), 16'h0000);
		rst(1'b0, 1'b0);
		repeat (100) @(posedge clk);
		#1 chk("ready", 16'(ready), 16'h0000);
		wait_ready(40000);
		chk("busy_only", 16'(busy), 16'h0000);
		rdc("ram_low", RAM_CLR_LO, 16'hFFFF, 16'h0000);
		rdc("ram_top", RAM_TOP, 16'hFFFF, 16'h0000);
		stop_test();
	end
endmodule : testbench
